// File: src/board_status_spi_reader.sv
// Purpose: serial master that polls board health items and presents them
// Assumes: slave answers 8-bit index with 16-bit value, MSB first, mode 0
// Notes:   round control on CLK, serial engine on LINK_CLK
`timescale 1ns/1ps
module board_status_spi_reader #(
  parameter int GAP_CYCLES = board_status_pkg::ROUND_GAP_CYCLES
) (
  input  wire logic                       CLK,
  input  wire logic                       RST_N,
  input  wire logic                       CE,
  input  wire logic                       LINK_CLK,
  output logic                            MOSI,
  input  wire logic                       MISO,
  output logic                            CS_N,
  output logic                            SCLK,
  output logic                            INFO_VALID,
  output board_status_pkg::status_t       STATUS
);
  import board_status_pkg::*;

  // ---------------- system clock domain ----------------
  round_state_t   state_r,    state_nxt;
  logic           req_tgl_r,  req_tgl_nxt;
  logic           valid_r,    valid_nxt;
  status_t        status_r,   status_nxt;
  logic [31:0]    gap_cnt_r,  gap_cnt_nxt;
  logic           rst_s1_r,   rst_s2_r;
  logic           done_s1_r,  done_s2_r, done_s3_r;
  logic           done_s1_nxt, done_s2_nxt, done_s3_nxt;
  logic           done_seen;

  // ---------------- link clock domain ----------------
  logic           lrst_s1_r,  lrst_s2_r;
  logic           lce_s1_r,   lce_s2_r;
  logic           req_s1_r,   req_s2_r, req_s3_r;
  logic           miso_s1_r,  miso_s2_r;
  logic           req_s1_nxt, req_s2_nxt, req_s3_nxt;
  logic           miso_s1_nxt, miso_s2_nxt;
  link_state_t    lstate_r,   lstate_nxt;
  logic [4:0]     item_r,     item_nxt;
  logic [4:0]     bit_cnt_r,  bit_cnt_nxt;
  logic [2:0]     div_r,      div_nxt;
  logic           sclk_r,     sclk_nxt;
  logic           cs_n_r,     cs_n_nxt;
  logic           mosi_r,     mosi_nxt;
  logic [23:0]    shift_r,    shift_nxt;
  logic           done_tgl_r, done_tgl_nxt;
  logic           mem_we;
  logic [15:0]    mem [ITEM_COUNT];
  logic           req_seen;

  localparam logic [4:0] LAST_ITEM = 5'(ITEM_COUNT - 1);
  localparam logic [4:0] LAST_BIT  = 5'(FRAME_BITS - 1);
  localparam logic [2:0] HALF_END  = 3'(SCLK_HALF - 1);
  localparam logic [2:0] IDLE_END  = 3'(CS_IDLE - 1);
  localparam logic [31:0] GAP_END  = 32'(GAP_CYCLES - 1);

  // ---------------- round control (CLK) ----------------
  assign done_seen = done_s2_r ^ done_s3_r;

  always_comb begin
    logic [ITEM_COUNT*ITEM_W-1:0] flat;
    flat        = '0;
    state_nxt   = state_r;
    req_tgl_nxt = req_tgl_r;
    valid_nxt   = valid_r;
    status_nxt  = status_r;
    gap_cnt_nxt = gap_cnt_r;
    done_s1_nxt = done_s1_r;
    done_s2_nxt = done_s2_r;
    done_s3_nxt = done_s3_r;
    for (int i = 0; i < ITEM_COUNT; i++) begin
      flat[(ITEM_COUNT-1-i)*ITEM_W +: ITEM_W] = mem[i];
    end
    if (CE) begin
      // done stages pause with the rest, so a frozen round
      // can neither miss nor double count its completion
      done_s1_nxt = done_tgl_r;
      done_s2_nxt = done_s1_r;
      done_s3_nxt = done_s2_r;
      case (state_r)
        R_START: begin
          req_tgl_nxt = ~req_tgl_r;
          valid_nxt   = 1'b0;
          state_nxt   = R_BUSY;
        end
        R_BUSY: begin
          // link memory is stable until the next request, so a
          // toggle handshake is enough to carry the whole set across
          if (done_seen) begin
            status_nxt = status_t'(flat);
            status_nxt.pin_status = flat[15:0] & PIN_STATUS_MASK;
            valid_nxt   = 1'b1;
            gap_cnt_nxt = '0;
            state_nxt   = R_GAP;
          end
        end
        default: begin
          if (gap_cnt_r >= GAP_END) begin
            state_nxt = R_START;
          end else begin
            gap_cnt_nxt = gap_cnt_r + 32'h1;
          end
        end
      endcase
    end
  end

  // reset sync
  // reset asserts at once but releases on a clock edge, so no round
  // flop sees a release that lands too close to its edge
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end

  always_ff @(posedge CLK or negedge rst_s2_r) begin
    if (!rst_s2_r) begin
      state_r   <= R_START;
      req_tgl_r <= 1'b0;
      valid_r   <= 1'b0;
      status_r  <= STATUS_RESET;
      gap_cnt_r <= '0;
      done_s1_r <= 1'b0;
      done_s2_r <= 1'b0;
      done_s3_r <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      req_tgl_r <= req_tgl_nxt;
      valid_r   <= valid_nxt;
      status_r  <= status_nxt;
      gap_cnt_r <= gap_cnt_nxt;
      done_s1_r <= done_s1_nxt;
      done_s2_r <= done_s2_nxt;
      done_s3_r <= done_s3_nxt;
    end
  end

  assign INFO_VALID = valid_r;
  assign STATUS     = status_r;

  // ---------------- link side resets and crossings ----------------
  // reset asserts at once but releases on a link edge
  always_ff @(posedge LINK_CLK or negedge RST_N) begin
    if (!RST_N) begin
      lrst_s1_r <= 1'b0;
      lrst_s2_r <= 1'b0;
    end else begin
      lrst_s1_r <= 1'b1;
      lrst_s2_r <= lrst_s1_r;
    end
  end

  always_ff @(posedge LINK_CLK or negedge lrst_s2_r) begin
    if (!lrst_s2_r) begin
      lce_s1_r  <= 1'b0;
      lce_s2_r  <= 1'b0;
      req_s1_r  <= 1'b0;
      req_s2_r  <= 1'b0;
      req_s3_r  <= 1'b0;
      miso_s1_r <= 1'b0;
      miso_s2_r <= 1'b0;
    end else begin
      lce_s1_r  <= CE;
      lce_s2_r  <= lce_s1_r;
      req_s1_r  <= req_s1_nxt;
      req_s2_r  <= req_s2_nxt;
      req_s3_r  <= req_s3_nxt;
      miso_s1_r <= miso_s1_nxt;
      miso_s2_r <= miso_s2_nxt;
    end
  end

  // data in sync
  // stages hold while frozen, so the bit taken at a falling serial
  // edge keeps its distance from the rising edge across a pause
  always_comb begin
    req_s1_nxt  = req_s1_r;
    req_s2_nxt  = req_s2_r;
    req_s3_nxt  = req_s3_r;
    miso_s1_nxt = miso_s1_r;
    miso_s2_nxt = miso_s2_r;
    if (lce_s2_r) begin
      req_s1_nxt  = req_tgl_r;
      req_s2_nxt  = req_s1_r;
      req_s3_nxt  = req_s2_r;
      miso_s1_nxt = MISO;
      miso_s2_nxt = miso_s1_r;
    end
  end

  assign req_seen = req_s2_r ^ req_s3_r;

  // ---------------- serial engine (LINK_CLK) ----------------
  always_comb begin
    lstate_nxt   = lstate_r;
    item_nxt     = item_r;
    bit_cnt_nxt  = bit_cnt_r;
    div_nxt      = div_r;
    sclk_nxt     = sclk_r;
    cs_n_nxt     = cs_n_r;
    mosi_nxt     = mosi_r;
    shift_nxt    = shift_r;
    done_tgl_nxt = done_tgl_r;
    mem_we       = 1'b0;
    if (lce_s2_r) begin
      case (lstate_r)
        L_IDLE: begin
          cs_n_nxt = 1'b1;
          sclk_nxt = 1'b0;
          if (req_seen) begin
            // wraps to item 0 at the first frame
            item_nxt   = '1;
            div_nxt    = '0;
            lstate_nxt = L_HOLD;
          end
        end
        L_SETUP: begin
          if (div_r == HALF_END) begin
            div_nxt    = '0;
            lstate_nxt = L_SHIFT;
          end else begin
            div_nxt = div_r + 3'h1;
          end
        end
        L_SHIFT: begin
          if (div_r == HALF_END) begin
            div_nxt = '0;
            if (!sclk_r) begin
              sclk_nxt = 1'b1;
            end else begin
              sclk_nxt    = 1'b0;
              // data in taken as clock falls
              shift_nxt   = {shift_r[22:0], miso_s2_r};
              mosi_nxt    = shift_r[22];
              bit_cnt_nxt = bit_cnt_r + 5'h1;
              if (bit_cnt_r == LAST_BIT) begin
                mem_we     = 1'b1;
                cs_n_nxt   = 1'b1;
                lstate_nxt = L_HOLD;
              end
            end
          end else begin
            div_nxt = div_r + 3'h1;
          end
        end
        default: begin
          // select stays high a few cycles between frames
          if (div_r == IDLE_END) begin
            div_nxt = '0;
            // round ends after the last item
            if (item_r == LAST_ITEM) begin
              done_tgl_nxt = ~done_tgl_r;
              lstate_nxt   = L_IDLE;
            end else begin
              item_nxt    = item_r + 5'h1;
              bit_cnt_nxt = '0;
              cs_n_nxt    = 1'b0;
              shift_nxt   = {3'h0, item_nxt, 16'h0000};
              mosi_nxt    = shift_nxt[23];
              lstate_nxt  = L_SETUP;
            end
          end else begin
            div_nxt = div_r + 3'h1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge LINK_CLK or negedge lrst_s2_r) begin
    if (!lrst_s2_r) begin
      lstate_r   <= L_IDLE;
      item_r     <= '0;
      bit_cnt_r  <= '0;
      div_r      <= '0;
      sclk_r     <= 1'b0;
      cs_n_r     <= 1'b1;
      mosi_r     <= 1'b0;
      shift_r    <= '0;
      done_tgl_r <= 1'b0;
    end else begin
      lstate_r   <= lstate_nxt;
      item_r     <= item_nxt;
      bit_cnt_r  <= bit_cnt_nxt;
      div_r      <= div_nxt;
      sclk_r     <= sclk_nxt;
      cs_n_r     <= cs_n_nxt;
      mosi_r     <= mosi_nxt;
      shift_r    <= shift_nxt;
      done_tgl_r <= done_tgl_nxt;
    end
  end

  // item store: not reset, read only after a completed round
  always_ff @(posedge LINK_CLK) begin
    if (mem_we) begin
      mem[item_r] <= shift_nxt[15:0];
    end
  end

  assign MOSI = mosi_r;
  assign CS_N = cs_n_r;
  assign SCLK = sclk_r;

endmodule : board_status_spi_reader

// File: src/board_status_pkg.sv
// Purpose: shared constants and types for the board status reader
// Assumes: 20 MHz system clock, separate link clock for the serial engine
// Notes:   item order on the link is the struct order, as the index constants below list
package board_status_pkg;

  localparam int CLK_MHZ          = 20;
  localparam int ROUND_GAP_US     = 1000;
  localparam int ROUND_GAP_CYCLES = ROUND_GAP_US * CLK_MHZ;

  localparam int ITEM_COUNT  = 17;
  localparam int ITEM_W      = 16;
  localparam int INDEX_W     = 8;
  localparam int FRAME_BITS  = INDEX_W + ITEM_W;
  localparam int SCLK_HALF   = 4;
  localparam int CS_IDLE     = 4;

  localparam logic [15:0] PIN_STATUS_MASK = 16'h00AF;

  // item indices sent on the link, in struct order
  localparam int IDX_BOARD_REV = 0;
  localparam int IDX_FW_REV    = 1;
  localparam int IDX_STATUS    = 16;

  typedef struct packed {
    logic [15:0] board_revision;
    logic [15:0] controller_firmware_revision;
    logic [15:0] supply_in_millivolts;
    logic [15:0] supply_in_milliamps;
    logic [15:0] core_rail1_millivolts;
    logic [15:0] core_rail1_milliamps;
    logic [15:0] core_rail2_millivolts;
    logic [15:0] core_rail2_milliamps;
    logic [15:0] fan1_rpm;
    logic [15:0] fan2_rpm;
    logic [15:0] ambient1_celsius;
    logic [15:0] ambient2_celsius;
    logic [15:0] fpga_core_celsius;
    logic [15:0] secure_manager_celsius;
    logic [15:0] transceiver_tile_e_celsius;
    logic [15:0] transceiver_tile_p_celsius;
    logic [15:0] pin_status;
  } status_t;

  localparam status_t STATUS_RESET = '0;

  typedef enum logic [1:0] {R_START, R_BUSY, R_GAP} round_state_t;
  typedef enum logic [1:0] {L_IDLE, L_SETUP, L_SHIFT, L_HOLD} link_state_t;

endpackage : board_status_pkg

// File: test/board_status_checker.sv
// Purpose: port-level checks for the status reader
// Assumes: GAP_CYCLES equals the bound instance value
// Notes:   the serial clock half period check is disabled and the gap length count pauses while CE is low
`timescale 1ns/1ps
module board_status_checker #(
  parameter int GAP_CYCLES = 20
) (
  input wire logic                      CLK,
  input wire logic                      RST_N,
  input wire logic                      CE,
  input wire logic                      LINK_CLK,
  input wire logic                      MOSI,
  input wire logic                      MISO,
  input wire logic                      CS_N,
  input wire logic                      SCLK,
  input wire logic                      INFO_VALID,
  input wire board_status_pkg::status_t STATUS
);
  import board_status_pkg::*;
  logic        sclk_q_r;
  logic [7:0]  rise_cnt_r;
  logic [15:0] high_cnt_r;
  always_ff @(posedge LINK_CLK or negedge RST_N) begin
    if (!RST_N) begin
      sclk_q_r   <= 1'b0;
      rise_cnt_r <= 8'h00;
    end else begin
      sclk_q_r   <= SCLK;
      rise_cnt_r <= CS_N ? 8'h00 : rise_cnt_r + {7'h00, SCLK & ~sclk_q_r};
    end
  end
  // counts only enabled cycles, as a frozen gap must not look long
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) high_cnt_r <= 16'h0000;
    else if (!INFO_VALID) high_cnt_r <= 16'h0000;
    else if (CE) high_cnt_r <= high_cnt_r + 16'h0001;
  end
  property p_reserved_zero;
    @(posedge CLK) disable iff (!RST_N) STATUS[15:8] == 8'h00 &&
      STATUS[6] == 1'b0 && STATUS[4] == 1'b0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved status bit set");
  property p_sclk_idle;
    @(posedge LINK_CLK) disable iff (!RST_N) CS_N |-> !SCLK;
  endproperty
  a_sclk_idle: assert property (p_sclk_idle)
    else $error("serial clock high while deselected");
  property p_status_hold;
    @(posedge CLK) disable iff (!RST_N)
      INFO_VALID && $past(INFO_VALID) |-> $stable(STATUS);
  endproperty
  a_status_hold: assert property (p_status_hold)
    else $error("status changed while valid");
  property p_gap_len;
    @(posedge CLK) disable iff (!RST_N)
      $fell(INFO_VALID) |-> high_cnt_r == GAP_CYCLES + 1;
  endproperty
  a_gap_len: assert property (p_gap_len)
    else $error("valid dropped at wrong time");
  property p_sclk_half;
    @(posedge LINK_CLK) disable iff (!RST_N || !CE)
      $rose(SCLK) |-> SCLK [*4] ##1 !SCLK;
  endproperty
  a_sclk_half: assert property (p_sclk_half)
    else $error("serial clock half period wrong");
  property p_cs_gap;
    @(posedge LINK_CLK) disable iff (!RST_N) $rose(CS_N) |-> CS_N [*4];
  endproperty
  a_cs_gap: assert property (p_cs_gap)
    else $error("select gap too short");
  property p_frame_len;
    @(posedge LINK_CLK) disable iff (!RST_N)
      $rose(CS_N) |-> rise_cnt_r == 8'h18;
  endproperty
  a_frame_len: assert property (p_frame_len)
    else $error("frame bit count wrong");
  property p_gap_idle;
    @(posedge CLK) disable iff (!RST_N)
      INFO_VALID && $past(INFO_VALID) |-> CS_N;
  endproperty
  a_gap_idle: assert property (p_gap_idle)
    else $error("link busy while valid");
endmodule : board_status_checker

bind board_status_spi_reader board_status_checker #(
  .GAP_CYCLES(GAP_CYCLES)
) board_status_checker_inst (
  .CLK(CLK), .RST_N(RST_N), .CE(CE), .LINK_CLK(LINK_CLK), .MOSI(MOSI),
  .MISO(MISO), .CS_N(CS_N), .SCLK(SCLK), .INFO_VALID(INFO_VALID),
  .STATUS(STATUS)
);

// File: test/board_status_slave_model.sv
// Purpose: behavioural slave answering item reads from a held image
// Assumes: 8-bit index then 16-bit value, MSB first, mode 0
// Notes:   idle data line flips so stale bits are never reused
`timescale 1ns/1ps
module board_status_slave_model (
  input  wire logic                      SCLK,
  input  wire logic                      CS_N,
  input  wire logic                      MOSI,
  output logic                           MISO,
  input  wire board_status_pkg::status_t IMAGE
);
  import board_status_pkg::*;
  int         bit_cnt;
  logic [7:0] index;
  initial MISO = 1'b0;
  always @(posedge SCLK or posedge CS_N) begin
    if (CS_N) begin
      bit_cnt = 0;
      MISO    = ~MISO;
    end else begin
      if (bit_cnt < 8) index = {index[6:0], MOSI};
      else MISO = IMAGE[279 - 16 * int'(index) - bit_cnt];
      bit_cnt++;
    end
  end
endmodule : board_status_slave_model

// File: test/board_status_spi_reader_test.sv
// Purpose: self-checking bench for the status reader
// Assumes: slave model answers from an image set during the gap
// Notes:   short round gap keeps the run brief
`timescale 1ns/1ps
module board_status_spi_reader_test;
  import board_status_pkg::*;
  localparam int GAP = 20;
  logic        clk, rst_n, ce, link_clk, mosi, miso, cs_n, sclk, info_valid;
  status_t     status, image, held;
  logic [15:0] lfsr;
  logic [3:0]  snap;
  int          num_errors, samples_checked, cycles;

  board_status_spi_reader #(.GAP_CYCLES(GAP)) board_status_spi_reader_inst (
    .CLK(clk), .RST_N(rst_n), .CE(ce), .LINK_CLK(link_clk), .MOSI(mosi),
    .MISO(miso), .CS_N(cs_n), .SCLK(sclk), .INFO_VALID(info_valid),
    .STATUS(status));
  board_status_slave_model board_status_slave_model_inst (
    .SCLK(sclk), .CS_N(cs_n), .MOSI(mosi), .MISO(miso), .IMAGE(image));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #6 link_clk = ~link_clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      summarize();
    end
  end

  function automatic logic [15:0] next_rand(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : next_rand
  function automatic status_t expect_of(input status_t s);
    expect_of = s;
    expect_of.pin_status = s.pin_status & 16'h00AF;
  endfunction : expect_of

  task automatic check_word(input string what, input status_t exp,
                            input status_t got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check_word
  task automatic check_bits(input string what, input logic [3:0] exp,
                            input logic [3:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check_bits
  // bounded, so a stuck flag ends in a mismatch rather than a hang
  task automatic wait_valid(input logic lvl);
    int n;
    n = 0;
    while (info_valid !== lvl && n < 4000) begin
      @(negedge clk);
      n++;
    end
    check_bits("info_valid", {3'h0, lvl}, {3'h0, info_valid});
  endtask : wait_valid
  task automatic check_reset;
    check_bits("idle pins", 4'h8, {cs_n, sclk, mosi, info_valid});
    check_word("reset status", '0, status);
  endtask : check_reset
  task automatic summarize;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize

  initial begin
    rst_n = 1'b0;
    ce    = 1'b1;
    lfsr  = 16'h0031;
    image = '1;
    repeat (20) @(posedge clk);
    check_reset();
    rst_n <= 1'b1;
    for (int r = 0; r < 5; r++) begin
      wait_valid(1'b1);
      held = expect_of(image);
      check_word("status", held, status);
      for (int i = 0; i < 17; i++) begin
        lfsr = next_rand(lfsr);
        image[i*16 +: 16] = (r == 0) ? 16'h0000 : lfsr;
      end
      wait_valid(1'b0);
      check_word("held status", held, status);
      if (r == 2) begin
        repeat (100) @(posedge clk);
        ce <= 1'b0;
        repeat (5) @(negedge clk);
        snap = {cs_n, sclk, mosi, info_valid};
        repeat (40) @(negedge clk);
        check_bits("held pins", snap, {cs_n, sclk, mosi, info_valid});
        @(posedge clk);
        ce <= 1'b1;
      end
      if (r == 3) begin
        repeat (200) @(posedge clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        check_reset();
        rst_n <= 1'b1;
      end
    end
    summarize();
  end
endmodule : board_status_spi_reader_test
